// ==== common/err_fault_pkg.sv ====
package err_fault_pkg;

  // ----------------------------------------------------------------------
  // Error codes
  // ----------------------------------------------------------------------
  localparam logic signed [15:0] ERR_MNEMONIC_LONG = -16'sd112;
  localparam logic signed [15:0] ERR_EXP_LARGE = -16'sd123;
  localparam logic signed [15:0] ERR_TOO_MANY_DIGITS = -16'sd124;
  localparam logic signed [15:0] ERR_CHAR_DATA_LONG = -16'sd144;
  localparam logic signed [15:0] ERR_QUEUE_OVERFLOW = -16'sd350;
  localparam logic signed [15:0] ERR_QUERY_INTERRUPTED = -16'sd410;
  localparam logic signed [15:0] ERR_QUERY_DEADLOCKED = -16'sd430;
  localparam logic signed [15:0] ERR_NONE = 16'sh0000;

  // ----------------------------------------------------------------------
  // Class ranges and event-status bit positions
  // ----------------------------------------------------------------------
  localparam logic signed [15:0] CMD_HI = -16'sd100;
  localparam logic signed [15:0] CMD_LO = -16'sd199;
  localparam logic signed [15:0] EXE_HI = -16'sd200;
  localparam logic signed [15:0] EXE_LO = -16'sd299;
  localparam logic signed [15:0] DEV_HI = -16'sd300;
  localparam logic signed [15:0] DEV_LO = -16'sd399;
  localparam logic signed [15:0] QRY_HI = -16'sd400;
  localparam logic signed [15:0] QRY_LO = -16'sd499;
  localparam int ESR_CMD_BIT = 5;
  localparam int ESR_EXE_BIT = 4;
  localparam int ESR_DEV_BIT = 3;
  localparam int ESR_QRY_BIT = 2;
  localparam logic [7:0] ESR_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Parser limits and queue
  // ----------------------------------------------------------------------
  localparam int MNEMONIC_MAX = 12;
  localparam int DIGITS_MAX = 255;
  localparam int EXPONENT_MAX = 32000;
  localparam int CHAR_DATA_MAX = 12;
  localparam int QUEUE_DEPTH = 8;
  localparam int QUERY_BUF_MAX = 4;
  localparam int QUES_INHIBIT_BIT = 9;
  localparam logic [15:0] QUES_RESET = 16'h0000;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic header_done;
    logic [7:0] header_len;
    logic number_done;
    logic [8:0] digit_count;
    logic [15:0] exponent_mag;
    logic char_done;
    logic [7:0] char_len;
  } parse_meas_t;

  typedef struct packed {
    logic valid;
    logic signed [15:0] code;
  } err_event_t;

  typedef enum logic [1:0] {
    PORT_FAULT_INHIBIT = 2'b00,
    PORT_DIGITAL_IO = 2'b01
  } port_mode_t;

endpackage : err_fault_pkg

// ==== core/err_queue.sv ====
`timescale 1ns/100ps
module err_queue #(
  parameter int DEPTH = err_fault_pkg::QUEUE_DEPTH
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire err_fault_pkg::err_event_t push_in,
  input wire logic pop_in,
  output logic signed [15:0] head_out,
  output logic empty_out
);

  localparam int AW = $clog2(DEPTH);

  logic signed [15:0] mem [DEPTH];
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] wr_ptr;
  logic [AW:0] count;
  logic do_pop;
  logic do_push;
  logic full_for_push;
  logic signed [15:0] wr_code;

  // ----------------------------------------------------------------------
  // Push and overflow
  // ----------------------------------------------------------------------
  // The last slot is held back for the overflow marker, so excess errors are
  // replaced by an overflow entry (one more for each error pushed in the same cycle as a pop while full) rather than silently lost.
  assign do_pop = pop_in && (count != '0);
  assign full_for_push = (count - (AW+1)'(do_pop)) >= (AW+1)'(DEPTH - 1);
  assign do_push = push_in.valid && (count != (AW+1)'(DEPTH) || do_pop);
  assign wr_code = full_for_push ? err_fault_pkg::ERR_QUEUE_OVERFLOW : push_in.code;

  always_ff @(posedge mclk_in) begin
    if (do_push) begin
      mem[wr_ptr] <= wr_code;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= '0;
    end else begin
      if (do_pop) begin
        rd_ptr <= AW'((32'(rd_ptr) + 1) % DEPTH);
      end
      if (do_push) begin
        wr_ptr <= AW'((32'(wr_ptr) + 1) % DEPTH);
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  assign head_out = (count == '0) ? err_fault_pkg::ERR_NONE : mem[rd_ptr];
  assign empty_out = (count == '0);

endmodule : err_queue

// ==== core/error_status_fault_inhibit.sv ====
`timescale 1ns/100ps
module error_status_fault_inhibit #(
  parameter int QUEUE_DEPTH = err_fault_pkg::QUEUE_DEPTH,
  parameter int QUERY_BUF_MAX = err_fault_pkg::QUERY_BUF_MAX
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire err_fault_pkg::parse_meas_t parse_in,
  input wire err_fault_pkg::err_event_t ext_err_in,
  input wire logic query_pending_in,
  input wire logic device_clear_in,
  input wire logic group_trigger_in,
  input wire logic [7:0] queries_in_string_in,
  input wire logic string_done_in,
  input wire logic error_queue_query_in,
  input wire logic esr_read_in,
  input wire logic ques_read_in,
  input wire logic oper_read_in,
  input wire logic [7:0] esr_enable_in,
  input wire logic [15:0] ques_enable_in,
  input wire logic [15:0] oper_enable_in,
  input wire logic [15:0] oper_cond_in,
  input wire logic [7:0] srq_enable_in,
  input wire err_fault_pkg::port_mode_t port_mode_in,
  input wire logic inhibit_in,
  input wire logic prot_clear_in,
  input wire logic ext_analog_prog_in,
  output logic signed [15:0] error_queue_query_out,
  output logic error_queue_empty_out,
  output logic [7:0] esr_out,
  output logic [15:0] ques_event_out,
  output logic [15:0] oper_event_out,
  output logic fault_indicator_out,
  output logic fault_indicator_oe_out,
  output logic output_enable_out,
  output logic remote_inhibit_protect_out,
  output logic prot_annunciator_out,
  output logic service_request_out
);

  logic [3:0] det;
  logic signed [15:0] det_code [4];
  logic q_int;
  logic q_dead;
  err_fault_pkg::err_event_t next_push;
  logic signed [15:0] head;
  logic empty;
  logic fault_mode;
  logic inhibit_low;
  logic [15:0] ques_rise;
  logic [15:0] oper_prev;
  logic [15:0] oper_rise;
  logic [7:0] next_esr_set;
  logic ques_sum;
  logic oper_sum;
  logic esr_sum;

  // ----------------------------------------------------------------------
  // Parser limit checks
  // ----------------------------------------------------------------------
  assign det[0] = parse_in.header_done && (parse_in.header_len > 8'(err_fault_pkg::MNEMONIC_MAX));
  assign det[1] = parse_in.number_done && (parse_in.digit_count > 9'(err_fault_pkg::DIGITS_MAX));
  assign det[2] = parse_in.number_done && (parse_in.exponent_mag > 16'(err_fault_pkg::EXPONENT_MAX));
  assign det[3] = parse_in.char_done && (parse_in.char_len > 8'(err_fault_pkg::CHAR_DATA_MAX));
  assign det_code[0] = err_fault_pkg::ERR_MNEMONIC_LONG;
  assign det_code[1] = err_fault_pkg::ERR_TOO_MANY_DIGITS;
  assign det_code[2] = err_fault_pkg::ERR_EXP_LARGE;
  assign det_code[3] = err_fault_pkg::ERR_CHAR_DATA_LONG;

  assign q_int = query_pending_in && (device_clear_in || group_trigger_in);
  assign q_dead = string_done_in && (queries_in_string_in > 8'(QUERY_BUF_MAX));

  // ----------------------------------------------------------------------
  // Error selection
  // ----------------------------------------------------------------------
  // Only one error can enter the queue per cycle; a lower priority error seen
  // in the same cycle is dropped, which keeps the queue a single-port write.
  always_comb begin
    next_push.valid = 1'b0;
    next_push.code = err_fault_pkg::ERR_NONE;
    if (q_int) begin
      next_push.valid = 1'b1;
      next_push.code = err_fault_pkg::ERR_QUERY_INTERRUPTED;
    end else if (q_dead) begin
      next_push.valid = 1'b1;
      next_push.code = err_fault_pkg::ERR_QUERY_DEADLOCKED;
    end else if (ext_err_in.valid) begin
      next_push.valid = 1'b1;
      next_push.code = ext_err_in.code;
    end else begin
      for (int i = 3; i >= 0; i--) begin
        if (det[i]) begin
          next_push.valid = 1'b1;
          next_push.code = det_code[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Event-status bits by class
  // ----------------------------------------------------------------------
  function automatic logic in_range(input logic signed [15:0] c, input logic signed [15:0] lo,
                                    input logic signed [15:0] hi);
    in_range = (c >= lo) && (c <= hi);
  endfunction : in_range

  always_comb begin
    next_esr_set = 8'h00;
    if (next_push.valid) begin
      next_esr_set[err_fault_pkg::ESR_CMD_BIT] =
        in_range(next_push.code, err_fault_pkg::CMD_LO, err_fault_pkg::CMD_HI);
      next_esr_set[err_fault_pkg::ESR_EXE_BIT] =
        in_range(next_push.code, err_fault_pkg::EXE_LO, err_fault_pkg::EXE_HI);
      next_esr_set[err_fault_pkg::ESR_DEV_BIT] =
        in_range(next_push.code, err_fault_pkg::DEV_LO, err_fault_pkg::DEV_HI);
      next_esr_set[err_fault_pkg::ESR_QRY_BIT] =
        in_range(next_push.code, err_fault_pkg::QRY_LO, err_fault_pkg::QRY_HI);
    end
  end

  // Set wins over the read-clear so an event in the read cycle survives.
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      esr_out <= err_fault_pkg::ESR_RESET;
    end else begin
      esr_out <= (esr_read_in ? 8'h00 : esr_out) | next_esr_set;
    end
  end

  // ----------------------------------------------------------------------
  // Error queue
  // ----------------------------------------------------------------------
  err_queue #(
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .push_in(next_push),
    .pop_in(error_queue_query_in),
    .head_out(head),
    .empty_out(empty)
  );

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      error_queue_query_out <= err_fault_pkg::ERR_NONE;
      error_queue_empty_out <= 1'b1;
    end else begin
      if (error_queue_query_in) begin
        error_queue_query_out <= head;
      end
      error_queue_empty_out <= empty;
    end
  end

  // ----------------------------------------------------------------------
  // Remote inhibit protection
  // ----------------------------------------------------------------------
  assign fault_mode = (port_mode_in == err_fault_pkg::PORT_FAULT_INHIBIT);
  assign inhibit_low = fault_mode && !inhibit_in;

  // The latch holds until inhibit is released and a clear arrives; a clear
  // while still inhibited is ignored.
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      remote_inhibit_protect_out <= 1'b0;
    end else if (inhibit_low) begin
      remote_inhibit_protect_out <= 1'b1;
    end else if (prot_clear_in) begin
      remote_inhibit_protect_out <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      prot_annunciator_out <= 1'b0;
      output_enable_out <= 1'b1;
    end else begin
      prot_annunciator_out <= inhibit_low || (remote_inhibit_protect_out && !prot_clear_in);
      // External analog programming keeps the output enabled; the inhibit latch and annunciator still trip.
      output_enable_out <= ext_analog_prog_in ||
        !(inhibit_low || (remote_inhibit_protect_out && !prot_clear_in));
    end
  end

  // ----------------------------------------------------------------------
  // Questionable and operation events
  // ----------------------------------------------------------------------
  always_comb begin
    ques_rise = 16'h0000;
    ques_rise[err_fault_pkg::QUES_INHIBIT_BIT] = inhibit_low && !remote_inhibit_protect_out;
  end

  assign oper_rise = oper_cond_in & ~oper_prev;

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      oper_prev <= 16'h0000;
    end else begin
      oper_prev <= oper_cond_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      ques_event_out <= err_fault_pkg::QUES_RESET;
      oper_event_out <= 16'h0000;
    end else begin
      ques_event_out <= (ques_read_in ? 16'h0000 : ques_event_out) | ques_rise;
      oper_event_out <= (oper_read_in ? 16'h0000 : oper_event_out) | oper_rise;
    end
  end

  // ----------------------------------------------------------------------
  // Summaries, fault output and service request
  // ----------------------------------------------------------------------
  assign ques_sum = |(ques_event_out & ques_enable_in);
  assign oper_sum = |(oper_event_out & oper_enable_in);
  assign esr_sum = |(esr_out & esr_enable_in);

  // Open-collector: the pin is only ever pulled low, never driven high.
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      fault_indicator_out <= 1'b0;
      fault_indicator_oe_out <= 1'b0;
    end else begin
      fault_indicator_out <= 1'b0;
      fault_indicator_oe_out <= fault_mode && (ques_sum || oper_sum || esr_sum);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      service_request_out <= 1'b0;
    end else begin
      service_request_out <= (srq_enable_in[3] && ques_sum) || (srq_enable_in[5] && esr_sum) ||
        (srq_enable_in[7] && oper_sum);
    end
  end

endmodule : error_status_fault_inhibit

// ==== verif/esf_properties.sv ====
`timescale 1ns/100ps
// ----------
// Port checks
// ----------
module esf_properties #(
  parameter int QUERY_BUF_MAX = err_fault_pkg::QUERY_BUF_MAX
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire err_fault_pkg::err_event_t ext_err_in,
  input wire logic query_pending_in,
  input wire logic device_clear_in,
  input wire logic group_trigger_in,
  input wire logic [7:0] queries_in_string_in,
  input wire logic string_done_in,
  input wire logic prot_clear_in,
  input wire logic inhibit_in,
  input wire logic ext_analog_prog_in,
  input wire err_fault_pkg::port_mode_t port_mode_in,
  input wire logic [7:0] esr_enable_in,
  input wire logic [15:0] ques_enable_in,
  input wire logic [15:0] oper_enable_in,
  input wire logic [7:0] srq_enable_in,
  input wire logic [7:0] esr_out,
  input wire logic [15:0] ques_event_out,
  input wire logic [15:0] oper_event_out,
  input wire logic fault_indicator_out,
  input wire logic fault_indicator_oe_out,
  input wire logic output_enable_out,
  input wire logic remote_inhibit_protect_out,
  input wire logic prot_annunciator_out,
  input wire logic service_request_out
);
  // Query faults outrank an external error, which is then dropped.
  logic hi_busy;
  logic ext_ok;
  logic qsum;
  logic fsum;
  logic signed [15:0] c;
  assign hi_busy = (query_pending_in && (device_clear_in || group_trigger_in)) ||
    (string_done_in && int'(queries_in_string_in) > QUERY_BUF_MAX);
  assign ext_ok = ext_err_in.valid && !hi_busy;
  assign c = ext_err_in.code;
  assign qsum = |(ques_event_out & ques_enable_in);
  assign fsum = |(esr_out & esr_enable_in) || qsum || |(oper_event_out & oper_enable_in);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_inhibit_low;
    port_mode_in == err_fault_pkg::PORT_FAULT_INHIBIT && !inhibit_in && !ext_analog_prog_in;
  endsequence
  sequence s_tripped;
    remote_inhibit_protect_out && prot_annunciator_out && !output_enable_out && ques_event_out[9];
  endsequence
  a_cmd_err_bit: assert property (ext_ok && c <= -16'sd100 && c >= -16'sd199 |=> esr_out[5])
    else $error("Command error bit missing.");
  a_dev_err_bit: assert property (ext_ok && c <= -16'sd300 && c >= -16'sd399 |=> esr_out[3])
    else $error("Device error bit missing.");
  a_query_int_bit: assert property (query_pending_in && device_clear_in |=> esr_out[2])
    else $error("Interrupted query bit missing.");
  a_inhibit_trip: assert property (s_inhibit_low |=> s_tripped)
    else $error("Inhibit did not trip.");
  a_fault_or_sum: assert property (fault_indicator_oe_out ==
    ($past(fsum) && $past(port_mode_in) == err_fault_pkg::PORT_FAULT_INHIBIT))
    else $error("Fault pin disagrees with summaries.");
  a_fault_pin_low: assert property (fault_indicator_oe_out |-> !fault_indicator_out)
    else $error("Fault pin not driven low.");
  a_clear_released: assert property ($fell(remote_inhibit_protect_out) |->
    $past(prot_clear_in && inhibit_in))
    else $error("Protection cleared without release.");
  a_srq_from_ques: assert property ((srq_enable_in[3] && qsum) [*3] |-> service_request_out)
    else $error("No service request.");
  a_analog_kept_on: assert property (ext_analog_prog_in && output_enable_out |=> output_enable_out)
    else $error("Inhibit cut analog output.");
endmodule : esf_properties

// ==== verif/fault_inhibit_wiring.sv ====
`timescale 1ns/100ps
// ----------
// Outside inhibit switch and clear
// ----------
module fault_inhibit_wiring (
  input wire logic mclk_in,
  input wire logic sw_close_in,
  input wire logic clear_req_in,
  output logic inhibit_out,
  output logic prot_clear_out
);
  // The input floats high, so an open switch reads high.
  assign inhibit_out = !sw_close_in;
  // A clear sent while still closed would be ignored, so it waits.
  always_ff @(posedge mclk_in) begin
    prot_clear_out <= clear_req_in && !sw_close_in;
  end
endmodule : fault_inhibit_wiring

// ==== verif/error_status_fault_inhibit_tb.sv ====
`timescale 1ns/100ps
// ----------
// Bench
// ----------
module error_status_fault_inhibit_tb;
  localparam logic signed [15:0] LIM [7] = '{err_fault_pkg::ERR_MNEMONIC_LONG,
    err_fault_pkg::ERR_TOO_MANY_DIGITS, err_fault_pkg::ERR_EXP_LARGE, err_fault_pkg::ERR_CHAR_DATA_LONG,
    err_fault_pkg::ERR_QUERY_INTERRUPTED, err_fault_pkg::ERR_QUERY_INTERRUPTED, err_fault_pkg::ERR_QUERY_DEADLOCKED};
  logic mclk_in = 1'b0, rst_b_in = 1'b0, sw_close = 1'b0, clr_req = 1'b0;
  err_fault_pkg::parse_meas_t parse_in = '0;
  err_fault_pkg::err_event_t ext_err_in = '0;
  logic query_pending_in = 1'b0, device_clear_in = 1'b0, group_trigger_in = 1'b0, string_done_in = 1'b0;
  logic error_queue_query_in = 1'b0, esr_read_in = 1'b0, ques_read_in = 1'b0, oper_read_in = 1'b0;
  logic ext_analog_prog_in = 1'b0, inhibit_in, prot_clear_in;
  logic [7:0] queries_in_string_in = '0, esr_enable_in = '0, srq_enable_in = '0, esr_exp;
  logic [15:0] ques_enable_in = '0, oper_enable_in = '0, oper_cond_in = '0, lfsr = 16'ha321;
  err_fault_pkg::port_mode_t port_mode_in = err_fault_pkg::PORT_FAULT_INHIBIT;
  logic signed [15:0] error_queue_query_out;
  logic signed [15:0] codes [10];
  logic [7:0] esr_out;
  logic [15:0] ques_event_out, oper_event_out;
  logic error_queue_empty_out, fault_indicator_out, fault_indicator_oe_out, output_enable_out;
  logic remote_inhibit_protect_out, prot_annunciator_out, service_request_out;
  int n_fail = 0, compares = 0, k, v;
  always #12.5 mclk_in = ~mclk_in;
  error_status_fault_inhibit u_dut (.mclk_in, .rst_b_in, .parse_in, .ext_err_in, .query_pending_in,
    .device_clear_in, .group_trigger_in, .queries_in_string_in, .string_done_in, .error_queue_query_in,
    .esr_read_in, .ques_read_in, .oper_read_in, .esr_enable_in, .ques_enable_in, .oper_enable_in,
    .oper_cond_in, .srq_enable_in, .port_mode_in, .inhibit_in, .prot_clear_in, .ext_analog_prog_in,
    .error_queue_query_out, .error_queue_empty_out, .esr_out, .ques_event_out, .oper_event_out,
    .fault_indicator_out, .fault_indicator_oe_out, .output_enable_out, .remote_inhibit_protect_out,
    .prot_annunciator_out, .service_request_out);
  fault_inhibit_wiring u_wire (.mclk_in, .sw_close_in(sw_close), .clear_req_in(clr_req),
    .inhibit_out(inhibit_in), .prot_clear_out(prot_clear_in));
  function automatic logic [15:0] next_rand();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : next_rand
  function automatic logic [7:0] class_mask(input logic signed [15:0] code);
    int n;
    n = -int'(code) / 100;
    return (n >= 1 && n <= 4) ? 8'h40 >> n : 8'h00;
  endfunction : class_mask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_in);
  endtask : cyc
  task automatic pop_check(input logic [15:0] exp);
    error_queue_query_in = 1'b1;
    cyc(1);
    error_queue_query_in = 1'b0;
    check(error_queue_query_out, exp);
    cyc(1);
  endtask : pop_check
  task automatic clear_events();
    {esr_read_in, ques_read_in, oper_read_in} = 3'b111;
    cyc(1);
    {esr_read_in, ques_read_in, oper_read_in} = 3'b000;
    cyc(1);
  endtask : clear_events
  task automatic summarize();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  initial begin
    cyc(10);
    check({15'h0000, output_enable_out}, 16'h0001);
    rst_b_in = 1'b1;
    esr_exp = 8'h00;
    for (int i = 0; i < 7; i++) begin
      k = i % 4 + 1;
      v = (i < 4) ? 100 * k + 99 * (i % 2) : 100 * k + int'(next_rand() % 16'd100);
      codes[i] = 16'(-v);
      esr_exp = esr_exp | class_mask(codes[i]);
      ext_err_in = {1'b1, codes[i]};
      cyc(1);
    end
    ext_err_in = '0;
    check({8'h00, esr_out}, {8'h00, esr_exp});
    check({15'h0000, error_queue_empty_out}, 16'h0000);
    for (int i = 0; i < 7; i++) pop_check(codes[i]);
    pop_check(16'h0000);
    check({15'h0000, error_queue_empty_out}, 16'h0001);
    clear_events();
    for (int f = 0; f < 7; f++) for (int o = 0; o < 2; o++) begin
      case (f)
        0: begin parse_in.header_done = 1'b1; parse_in.header_len = 8'(err_fault_pkg::MNEMONIC_MAX + o); end
        1: begin parse_in.number_done = 1'b1; parse_in.digit_count = 9'(err_fault_pkg::DIGITS_MAX + o); end
        2: begin parse_in.number_done = 1'b1; parse_in.exponent_mag = 16'(err_fault_pkg::EXPONENT_MAX + o); end
        3: begin parse_in.char_done = 1'b1; parse_in.char_len = 8'(err_fault_pkg::CHAR_DATA_MAX + o); end
        4: begin query_pending_in = o[0]; device_clear_in = 1'b1; end
        5: begin query_pending_in = o[0]; group_trigger_in = 1'b1; end
        default: begin string_done_in = 1'b1; queries_in_string_in = 8'(err_fault_pkg::QUERY_BUF_MAX + o); end
      endcase
      cyc(1);
      parse_in = '0;
      {query_pending_in, device_clear_in, group_trigger_in, string_done_in} = 4'h0;
      check({8'h00, esr_out}, o ? {8'h00, class_mask(LIM[f])} : 16'h0000);
      pop_check(o ? LIM[f] : 16'h0000);
      clear_events();
    end
    for (int i = 0; i < 10; i++) begin
      codes[i] = 16'(-(100 + int'(next_rand() % 16'd100)));
      ext_err_in = {1'b1, codes[i]};
      cyc(1);
    end
    ext_err_in = '0;
    for (int i = 0; i < 7; i++) pop_check(codes[i]);
    pop_check(err_fault_pkg::ERR_QUEUE_OVERFLOW);
    pop_check(16'h0000);
    clear_events();
    ques_enable_in = 16'h0200;
    srq_enable_in = 8'h08;
    sw_close = 1'b1;
    cyc(1);
    check({12'h000, remote_inhibit_protect_out, prot_annunciator_out, output_enable_out,
      ques_event_out[9]}, 16'h000d);
    cyc(2);
    check({14'h0000, fault_indicator_oe_out, service_request_out}, 16'h0003);
    clr_req = 1'b1;
    cyc(2);
    check({15'h0000, remote_inhibit_protect_out}, 16'h0001);
    sw_close = 1'b0;
    cyc(2);
    clr_req = 1'b0;
    check({14'h0000, remote_inhibit_protect_out, output_enable_out}, 16'h0001);
    check({14'h0000, fault_indicator_oe_out, fault_indicator_out}, 16'h0002);
    clear_events();
    cyc(1);
    check({15'h0000, fault_indicator_oe_out}, 16'h0000);
    ext_analog_prog_in = 1'b1;
    sw_close = 1'b1;
    cyc(2);
    check({15'h0000, output_enable_out}, 16'h0001);
    {ext_analog_prog_in, sw_close, clr_req} = 3'b001;
    cyc(2);
    clr_req = 1'b0;
    clear_events();
    port_mode_in = err_fault_pkg::PORT_DIGITAL_IO;
    esr_enable_in = 8'hff;
    sw_close = 1'b1;
    ext_err_in = {1'b1, -16'sd222};
    cyc(1);
    ext_err_in = '0;
    cyc(2);
    check({14'h0000, remote_inhibit_protect_out, fault_indicator_oe_out}, 16'h0000);
    port_mode_in = err_fault_pkg::PORT_FAULT_INHIBIT;
    sw_close = 1'b0;
    esr_enable_in = 8'h00;
    clear_events();
    oper_enable_in = 16'h0001;
    oper_cond_in = 16'h0001;
    cyc(3);
    check({15'h0000, fault_indicator_oe_out}, 16'h0001);
    check(oper_event_out, 16'h0001);
    summarize();
  end
endmodule : error_status_fault_inhibit_tb
bind error_status_fault_inhibit esf_properties #(.QUERY_BUF_MAX(QUERY_BUF_MAX)) u_props (.mclk_in, .rst_b_in,
  .ext_err_in, .query_pending_in, .device_clear_in, .group_trigger_in, .queries_in_string_in, .string_done_in,
  .prot_clear_in, .inhibit_in, .ext_analog_prog_in, .port_mode_in, .esr_enable_in, .ques_enable_in,
  .oper_enable_in, .srq_enable_in, .esr_out, .ques_event_out, .oper_event_out, .fault_indicator_out,
  .fault_indicator_oe_out, .output_enable_out, .remote_inhibit_protect_out, .prot_annunciator_out,
  .service_request_out);
